// file: tsa_top.sv
// Temperature alarm slave: two-wire register port plus over-temperature alarm.
// Assumes a converter front end on clock_i and a bus master that clocks scl_i.
//
// How it works
// - Answer address 1001 plus three select pins.
// - Temperatures are 9-bit two's complement half degrees.
// - Config bit 0 set stops conversions.
// - Shutdown in interrupt mode clears the alarm.
// - Bus and limit registers keep working in shutdown.
// - Fault queue needs 1, 2, 4, 6 consecutive faults.
// - Comparator alarm: above trip on, below hysteresis off.
// - Interrupt alarm holds until any register read.
// - After clearing, next interrupt needs below hysteresis.
// - Config bit 1 selects comparator or interrupt.
// - Config bit 2 sets polarity; pin only pulls low.
// - Pointer low bits select the data register.
// - Pointer resets to zero and persists.
// - Temperature register ignores writes.
// - Reads use stored pointer or repeated start.
// - Read returns high byte first, MSB first.
// - Last read byte accepts ack or nack.
// - Stop returns the bus engine to idle.
// - Temperature sits in bits 15 to 7.
// - Limits share layout; defaults 80 and 75.
// - Configuration clears at reset; top bits are stored as written.
// - A read freezes and restarts the conversion.
module tsa_top
	import tsa_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	input  wire logic       addr_select_bit2_i,
	input  wire logic       addr_select_bit1_i,
	input  wire logic       addr_select_bit0_i,
	input  wire logic [8:0] conv_result_i,
	input  wire logic       conv_done_i,
	output logic            conv_enable_o,
	output logic            alarm_o,
	output logic            alarm_oe_o
);
	// Link side, clocked by scl_i.
	tsa_link_st_t st_q;
	logic [2:0] bit_q;
	logic [6:0] sh_q;
	logic [7:0] tx_q;
	logic [1:0] byte_q;
	logic [1:0] register_select_field_q;
	logic [7:0] cfg_q;
	logic [8:0] hyst_q;
	logic [8:0] trip_q;
	logic [7:0] hi_q;
	logic       rw_q;
	logic       start_tgl_q;
	logic       stop_tgl_q;
	logic       start_ack_q;
	logic       stop_ack_q;
	logic       cfg_tgl_q;
	logic       rd_tgl_q;
	logic       busy_q;
	logic [8:0] temp_l_q;
	logic       tmp_seen_q;
	logic       tmp_tgl_s;
	logic [2:0] addr_sel_s;
	logic [7:0] rx_byte;
	logic [15:0] rd_word;
	logic       start_seen;
	logic       stop_seen;
	logic       last_bit;
	logic       wr_ev;

	// System side, clocked by clock_i.
	logic [8:0] temp_q;
	logic       tmp_tgl_q;
	logic [7:0] cfg_s_q;
	logic [8:0] hyst_s_q;
	logic [8:0] trip_s_q;
	logic [2:0] cnt_q;
	logic       dir_q;
	logic       pend_q;
	logic       cfg_tgl_s;
	logic       cfg_seen_q;
	logic       rd_tgl_s;
	logic       rd_seen_q;
	logic       busy_s;
	logic       sd;
	logic       intm;
	logic       pol;
	logic       sample;
	logic       fault;
	logic       trig;
	logic       rd_ev;
	logic       active;
	logic [2:0] need;
	logic [2:0] cnt_nx;

	// The sda-edge flops see start and stop; the scl-side engine acknowledges
	// them at its next rising edge, when sda has been settled for half a period.
	always_ff @(negedge sda_i or negedge rstn_i) begin
		if (!rstn_i) begin
			start_tgl_q <= 1'b0;
		end else if (scl_i) begin
			start_tgl_q <= ~start_tgl_q;
		end
	end

	always_ff @(posedge sda_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stop_tgl_q <= 1'b0;
		end else if (scl_i) begin
			stop_tgl_q <= ~stop_tgl_q;
		end
	end

	tsa_sync2 #(.W(3)) u_addr_sync (
		.clk_i  (scl_i),
		.rstn_i (rstn_i),
		.d_i    ({addr_select_bit2_i, addr_select_bit1_i, addr_select_bit0_i}),
		.q_o    (addr_sel_s)
	);

	tsa_sync2 #(.W(1)) u_tmp_sync (
		.clk_i  (scl_i),
		.rstn_i (rstn_i),
		.d_i    (tmp_tgl_q),
		.q_o    (tmp_tgl_s)
	);

	assign start_seen = start_tgl_q ^ start_ack_q;
	assign stop_seen  = stop_tgl_q ^ stop_ack_q;
	assign rx_byte    = {sh_q, sda_i};
	assign last_bit   = (bit_q == TSA_LAST_BIT);
	assign wr_ev      = (st_q == TSA_S_WDATA) && last_bit && !start_seen && !stop_seen;

	always_comb begin
		unique case (register_select_field_q)
			TSA_PTR_TEMP: rd_word = {temp_l_q, TSA_LOW_PAD};
			TSA_PTR_CFG:  rd_word = {cfg_q, TSA_BYTE_PAD};
			TSA_PTR_HYST: rd_word = {hyst_q, TSA_LOW_PAD};
			TSA_PTR_TRIP: rd_word = {trip_q, TSA_LOW_PAD};
		endcase
	end

	always_ff @(posedge scl_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q        <= TSA_S_IDLE;
			bit_q       <= '0;
			sh_q        <= '0;
			tx_q        <= '0;
			byte_q      <= '0;
			rw_q        <= 1'b0;
			busy_q      <= 1'b0;
			rd_tgl_q    <= 1'b0;
			start_ack_q <= 1'b0;
			stop_ack_q  <= 1'b0;
			register_select_field_q <= TSA_PTR_TEMP;
		end else begin
			start_ack_q <= start_tgl_q;
			stop_ack_q  <= stop_tgl_q;
			if (start_seen) begin
				st_q   <= TSA_S_ADDR;
				sh_q   <= {sh_q[5:0], sda_i};
				bit_q  <= 3'h1;
				busy_q <= 1'b0;
			end else if (stop_seen) begin
				st_q   <= TSA_S_IDLE;
				busy_q <= 1'b0;
			end else begin
				unique case (st_q)
					TSA_S_IDLE: begin
						bit_q <= '0;
					end
					TSA_S_ADDR: begin
						sh_q  <= rx_byte[6:0];
						bit_q <= bit_q + 3'h1;
						if (last_bit) begin
							if (rx_byte[7:1] == {TSA_ADDR_HI, addr_sel_s}) begin
								st_q <= TSA_S_ADDR_ACK;
								rw_q <= rx_byte[0];
								if (rx_byte[0]) begin
									rd_tgl_q <= ~rd_tgl_q;
								end
							end else begin
								st_q <= TSA_S_IDLE;
							end
						end
					end
					TSA_S_ADDR_ACK: begin
						bit_q  <= '0;
						byte_q <= '0;
						tx_q   <= rd_word[15:8];
						st_q   <= rw_q ? TSA_S_RDATA : TSA_S_PTR;
					end
					TSA_S_PTR: begin
						sh_q  <= rx_byte[6:0];
						bit_q <= bit_q + 3'h1;
						if (last_bit) begin
							// Upper pointer bits are trusted to be zero and dropped.
							register_select_field_q <= rx_byte[1:0];
							st_q <= TSA_S_PTR_ACK;
						end
					end
					TSA_S_PTR_ACK: begin
						bit_q <= '0;
						st_q  <= TSA_S_WDATA;
					end
					TSA_S_WDATA: begin
						sh_q  <= rx_byte[6:0];
						bit_q <= bit_q + 3'h1;
						if (last_bit) begin
							st_q <= TSA_S_WDATA_ACK;
						end
					end
					TSA_S_WDATA_ACK: begin
						bit_q <= '0;
						st_q  <= TSA_S_WDATA;
						if (byte_q != TSA_WR_DONE) begin
							byte_q <= byte_q + 2'h1;
						end
					end
					TSA_S_RDATA: begin
						tx_q   <= {tx_q[6:0], 1'b0};
						bit_q  <= bit_q + 3'h1;
						busy_q <= !last_bit;
						if (last_bit) begin
							st_q <= TSA_S_RDATA_ACK;
						end
					end
					TSA_S_RDATA_ACK: begin
						bit_q  <= '0;
						byte_q <= {1'b0, ~byte_q[0]};
						tx_q   <= byte_q[0] ? rd_word[15:8] : rd_word[7:0];
						st_q   <= sda_i ? TSA_S_IDLE : TSA_S_RDATA;
					end
				endcase
			end
		end
	end

	// Register writes; limits land only once both bytes have arrived.
	always_ff @(posedge scl_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_q     <= TSA_CFG_RST;
			hyst_q    <= TSA_HYST_RST;
			trip_q    <= TSA_TRIP_RST;
			hi_q      <= '0;
			cfg_tgl_q <= 1'b0;
		end else if (wr_ev) begin
			if (byte_q == 2'h0) begin
				hi_q <= rx_byte;
				if (register_select_field_q == TSA_PTR_CFG) begin
					cfg_q     <= rx_byte;
					cfg_tgl_q <= ~cfg_tgl_q;
				end
			end else if (byte_q == 2'h1) begin
				if (register_select_field_q == TSA_PTR_HYST) begin
					hyst_q    <= {hi_q, rx_byte[7]};
					cfg_tgl_q <= ~cfg_tgl_q;
				end else if (register_select_field_q == TSA_PTR_TRIP) begin
					trip_q    <= {hi_q, rx_byte[7]};
					cfg_tgl_q <= ~cfg_tgl_q;
				end
			end
			// Writes aimed at the temperature register are dropped here.
		end
	end

	// The sys side holds temp_q still for several link edges after each toggle.
	always_ff @(posedge scl_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tmp_seen_q <= 1'b0;
			temp_l_q   <= '0;
		end else begin
			tmp_seen_q <= tmp_tgl_s;
			if (tmp_seen_q != tmp_tgl_s) begin
				temp_l_q <= temp_q;
			end
		end
	end

	// Data changes on the falling edge so it is stable before the master samples.
	always_ff @(negedge scl_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sda_oe_o <= 1'b0;
			sda_o    <= 1'b0;
		end else begin
			sda_o    <= 1'b0;
			sda_oe_o <= (st_q == TSA_S_ADDR_ACK) || (st_q == TSA_S_PTR_ACK)
				|| (st_q == TSA_S_WDATA_ACK)
				|| ((st_q == TSA_S_RDATA) && !tx_q[7]);
		end
	end

	tsa_sync2 #(.W(3)) u_sys_sync (
		.clk_i  (clock_i),
		.rstn_i (rstn_i),
		.d_i    ({cfg_tgl_q, rd_tgl_q, busy_q}),
		.q_o    ({cfg_tgl_s, rd_tgl_s, busy_s})
	);

	assign sd     = cfg_s_q[TSA_CFG_SD];
	assign intm   = cfg_s_q[TSA_CFG_INT];
	assign pol    = cfg_s_q[TSA_CFG_POL];
	assign rd_ev  = rd_tgl_s ^ rd_seen_q;
	assign sample = conv_done_i && !sd && !busy_s;
	assign fault  = dir_q ? ($signed(conv_result_i) < $signed(hyst_s_q))
		: ($signed(conv_result_i) > $signed(trip_s_q));
	assign cnt_nx = cnt_q + 3'h1;
	assign trig   = sample && fault && (cnt_nx >= need);
	assign active = intm ? pend_q : dir_q;

	always_comb begin
		unique case (cfg_s_q[TSA_CFG_FQ_HI:TSA_CFG_FQ_LO])
			TSA_FQ_CODE1: need = TSA_FQ_N1;
			TSA_FQ_CODE2: need = TSA_FQ_N2;
			TSA_FQ_CODE4: need = TSA_FQ_N4;
			default:      need = TSA_FQ_N6;
		endcase
	end

	// Word copies are safe: link words stay put far longer than the sync delay.
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_seen_q <= 1'b0;
			rd_seen_q  <= 1'b0;
			cfg_s_q    <= TSA_CFG_RST;
			hyst_s_q   <= TSA_HYST_RST;
			trip_s_q   <= TSA_TRIP_RST;
		end else begin
			cfg_seen_q <= cfg_tgl_s;
			rd_seen_q  <= rd_tgl_s;
			if (cfg_seen_q != cfg_tgl_s) begin
				cfg_s_q  <= cfg_q;
				hyst_s_q <= hyst_q;
				trip_s_q <= trip_q;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			temp_q    <= '0;
			tmp_tgl_q <= 1'b0;
		end else if (sample) begin
			temp_q    <= conv_result_i;
			tmp_tgl_q <= ~tmp_tgl_q;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= '0;
			dir_q <= 1'b0;
		end else if (sample) begin
			cnt_q <= (fault && !trig) ? cnt_nx : 3'h0;
			if (trig) begin
				dir_q <= ~dir_q;
			end
		end
	end

	// A new trip in the same cycle as a read clear keeps the alarm set.
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pend_q <= 1'b0;
		end else if (trig && intm) begin
			pend_q <= 1'b1;
		end else if (rd_ev || sd) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			alarm_oe_o    <= 1'b0;
			alarm_o       <= 1'b0;
			conv_enable_o <= 1'b0;
		end else begin
			alarm_o       <= 1'b0;
			alarm_oe_o    <= pol ? !active : active;
			conv_enable_o <= !sd && !busy_s;
		end
	end

	sequence seq_int_trip;
		trig && intm;
	endsequence

	sequence seq_read_clear;
		rd_ev && !trig;
	endsequence

	AST_SD_STOPS_CONV: assert property (@(posedge clock_i) disable iff (!rstn_i)
		sd |=> !conv_enable_o)
		else $error("conversion enabled during shutdown");
	AST_SD_CLEARS_INT: assert property (@(posedge clock_i) disable iff (!rstn_i)
		sd |=> !pend_q ##1 (!$past(intm) || (alarm_oe_o == $past(pol))))
		else $error("shutdown did not clear interrupt alarm");
	AST_INT_SET_HOLD: assert property (@(posedge clock_i) disable iff (!rstn_i)
		seq_int_trip ##1 (!rd_ev && !sd && intm) |-> pend_q ##1 (alarm_oe_o == !$past(pol)))
		else $error("interrupt alarm not held after trip");
	AST_READ_CLEARS: assert property (@(posedge clock_i) disable iff (!rstn_i)
		seq_read_clear |=> !pend_q)
		else $error("read did not clear interrupt alarm");
	AST_PIN_NEVER_HIGH: assert property (@(posedge clock_i) disable iff (!rstn_i)
		alarm_o == 1'b0)
		else $error("alarm pin driven high");
	AST_POLARITY: assert property (@(posedge clock_i) disable iff (!rstn_i)
		##1 alarm_oe_o == ($past(pol) ? !$past(active) : $past(active)))
		else $error("alarm polarity wrong");
	AST_FAULT_BOUND: assert property (@(posedge clock_i) disable iff (!rstn_i)
		sample && fault && (cnt_nx < need) |=> (cnt_q == $past(cnt_nx)) && $stable(dir_q))
		else $error("fault queue tripped early");
	AST_NONFAULT_CLR: assert property (@(posedge clock_i) disable iff (!rstn_i)
		sample && !fault |=> cnt_q == 3'h0)
		else $error("fault count kept after good sample");
	AST_READ_FREEZE: assert property (@(posedge clock_i) disable iff (!rstn_i)
		busy_s |=> $stable(temp_q) && !conv_enable_o)
		else $error("temperature changed during read");
	AST_ADDR_ACK: assert property (@(posedge scl_i) disable iff (!rstn_i)
		(st_q == TSA_S_ADDR_ACK) && !start_seen |-> sda_oe_o)
		else $error("matched address not acknowledged");
	AST_STOP_IDLE: assert property (@(posedge scl_i) disable iff (!rstn_i)
		stop_seen && !start_seen |=> st_q == TSA_S_IDLE)
		else $error("stop did not idle the link");
endmodule : tsa_top

// file: tsa_pkg.sv
// Shared constants and types of the temperature alarm slave.
// Assumes a 10 MHz system clock and a two-wire bus clocked by its master.
package tsa_pkg;
	localparam logic [3:0] TSA_ADDR_HI   = 4'h9;
	localparam logic [1:0] TSA_PTR_TEMP  = 2'h0;
	localparam logic [1:0] TSA_PTR_CFG   = 2'h1;
	localparam logic [1:0] TSA_PTR_HYST  = 2'h2;
	localparam logic [1:0] TSA_PTR_TRIP  = 2'h3;
	localparam int         TSA_CFG_SD    = 0;
	localparam int         TSA_CFG_INT   = 1;
	localparam int         TSA_CFG_POL   = 2;
	localparam int         TSA_CFG_FQ_LO = 3;
	localparam int         TSA_CFG_FQ_HI = 4;
	localparam logic [7:0] TSA_CFG_RST   = 8'h00;
	localparam logic [8:0] TSA_TRIP_RST  = 9'h0a0;
	localparam logic [8:0] TSA_HYST_RST  = 9'h096;
	localparam logic [1:0] TSA_FQ_CODE1  = 2'h0;
	localparam logic [1:0] TSA_FQ_CODE2  = 2'h1;
	localparam logic [1:0] TSA_FQ_CODE4  = 2'h2;
	localparam logic [2:0] TSA_FQ_N1     = 3'h1;
	localparam logic [2:0] TSA_FQ_N2     = 3'h2;
	localparam logic [2:0] TSA_FQ_N4     = 3'h4;
	localparam logic [2:0] TSA_FQ_N6     = 3'h6;
	localparam logic [6:0] TSA_LOW_PAD   = 7'h00;
	localparam logic [7:0] TSA_BYTE_PAD  = 8'h00;
	localparam logic [2:0] TSA_LAST_BIT  = 3'h7;
	localparam logic [1:0] TSA_WR_DONE   = 2'h2;

	typedef enum logic [3:0] {
		TSA_S_IDLE,
		TSA_S_ADDR,
		TSA_S_ADDR_ACK,
		TSA_S_PTR,
		TSA_S_PTR_ACK,
		TSA_S_WDATA,
		TSA_S_WDATA_ACK,
		TSA_S_RDATA,
		TSA_S_RDATA_ACK
	} tsa_link_st_t;
endpackage : tsa_pkg

// file: tsa_sync2.sv
// Two flip-flop synchroniser for levels and toggles.
// Assumes the input is stable long enough to be seen by the destination clock.
module tsa_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule : tsa_sync2

// file: tsa_bus_master.sv
// Behavioural two-wire bus master that drives the link of the alarm slave.
// Assumes an open-drain data wire with a pull-up, resolved in the bench.
module tsa_bus_master (
	output logic      scl_o,
	output logic      sda_low_o,
	input  wire logic sda_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic ack_ok;
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
		ack_ok = 1'b1;
	end
	// The clock only toggles with data high, so no start or stop is seen.
	task automatic idle_clk();
		repeat (2) begin
			#40 scl_o = 1'b0;
			#40 scl_o = 1'b1;
		end
	endtask : idle_clk
	task automatic put_bit(input logic b);
		sda_low_o = ~b;
		#20 scl_o = 1'b1;
		#40 scl_o = 1'b0;
		#20;
	endtask : put_bit
	task automatic get_bit(output logic b);
		sda_low_o = 1'b0;
		#20 scl_o = 1'b1;
		b = sda_i;
		#40 scl_o = 1'b0;
		#20;
	endtask : get_bit
	task automatic start();
		sda_low_o = 1'b0;
		#20 scl_o = 1'b1;
		#20 sda_low_o = 1'b1;
		#20 scl_o = 1'b0;
		#20;
	endtask : start
	task automatic stop();
		sda_low_o = 1'b1;
		#20 scl_o = 1'b1;
		#20 sda_low_o = 1'b0;
		#20;
	endtask : stop
	task automatic send(input logic [7:0] v);
		logic b;
		for (int i = 7; i >= 0; i--) put_bit(v[i]);
		get_bit(b);
		ack_ok = ack_ok & ~b;
	endtask : send
	task automatic recv(output logic [7:0] v, input logic last);
		for (int i = 7; i >= 0; i--) get_bit(v[i]);
		put_bit(last);
	endtask : recv
	task automatic wr(input logic [6:0] a, input logic [1:0] p, input int n,
		input logic [15:0] d);
		start();
		send({a, 1'b0});
		send({6'h00, p});
		if (n > 0) send(d[15:8]);
		if (n > 1) send(d[7:0]);
		stop();
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic setp, input logic [1:0] p,
		input int nb, output logic [15:0] v);
		v = 16'h0000;
		start();
		if (setp) begin
			send({a, 1'b0});
			send({6'h00, p});
			start();
		end
		send({a, 1'b1});
		recv(v[15:8], nb == 1);
		if (nb > 1) recv(v[7:0], 1'b1);
		stop();
	endtask : rd
endmodule : tsa_bus_master

// file: tb.sv
// Self-checking bench of the temperature alarm slave.
// Assumes address straps 101 and a pull-up on the open-drain data wire.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import tsa_pkg::*;
	localparam logic [6:0] ADDR = 7'h4d;
	logic        clock_i;
	logic        rstn_i;
	logic        scl;
	logic        sda_low;
	logic [8:0]  res;
	logic        done;
	logic [2:0]  straps;
	logic        sda_o, sda_oe, conv_en, alarm_o, alarm_oe;
	logic [15:0] v;
	wire         sda_w;
	int          miscompares, num_checks, cycles;
	assign sda_w = ~(sda_low | sda_oe);
	tsa_bus_master mst (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));
	tsa_top dut (
		.clock_i            (clock_i),
		.rstn_i             (rstn_i),
		.scl_i              (scl),
		.sda_i              (sda_w),
		.sda_o              (sda_o),
		.sda_oe_o           (sda_oe),
		.addr_select_bit2_i (straps[2]),
		.addr_select_bit1_i (straps[1]),
		.addr_select_bit0_i (straps[0]),
		.conv_result_i      (res),
		.conv_done_i        (done),
		.conv_enable_o      (conv_en),
		.alarm_o            (alarm_o),
		.alarm_oe_o         (alarm_oe)
	);
	always #50 clock_i = ~clock_i;
	// A hung handshake would otherwise run forever.
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask : chk
	task automatic waitc(input int n);
		repeat (n) @(negedge clock_i);
	endtask : waitc
	task automatic pulse(input logic [8:0] r);
		@(negedge clock_i);
		res = r;
		done = 1'b1;
		@(negedge clock_i);
		done = 1'b0;
		waitc(4);
	endtask : pulse
	task automatic cfg(input logic [7:0] c);
		mst.wr(ADDR, TSA_PTR_CFG, 1, {c, 8'h00});
		waitc(10);
	endtask : cfg
	task automatic t_temp();
		pulse(9'h032);
		mst.rd(ADDR, 1'b0, 2'h0, 2, v);
		chk("temp", 16'h1900, v);
		pulse(9'h1ce);
		mst.rd(ADDR, 1'b0, 2'h0, 2, v);
		chk("neg temp", 16'he700, v);
		mst.wr(ADDR, TSA_PTR_TEMP, 2, 16'h7f80);
		mst.rd(ADDR, 1'b0, 2'h0, 2, v);
		chk("temp ro", 16'he700, v);
		mst.rd(ADDR, 1'b0, 2'h0, 1, v);
		chk("short read", 16'he700, v);
		fork
			mst.rd(ADDR, 1'b0, 2'h0, 2, v);
			begin
				#1300;
				chk("conv off", 16'h0000, {15'h0, conv_en});
				pulse(9'h0ff);
			end
		join
		waitc(10);
		chk("conv back", 16'h0001, {15'h0, conv_en});
		mst.rd(ADDR, 1'b0, 2'h0, 2, v);
		chk("kept temp", 16'he700, v);
		chk("acks", 16'h0001, {15'h0, mst.ack_ok});
		$display("test temp done");
	endtask : t_temp
	task automatic t_defaults();
		mst.rd(ADDR, 1'b1, TSA_PTR_HYST, 2, v);
		chk("hyst", 16'h4b00, v);
		mst.rd(ADDR, 1'b1, TSA_PTR_TRIP, 2, v);
		chk("trip", 16'h5000, v);
		mst.rd(ADDR, 1'b1, TSA_PTR_CFG, 1, v);
		chk("cfg", 16'h0000, v);
		mst.wr(7'h48, TSA_PTR_CFG, 0, 16'h0000);
		chk("foreign addr", 16'h0000, {15'h0, mst.ack_ok});
		mst.ack_ok = 1'b1;
		// Straps move only with the bus idle; two idle clocks let them settle.
		@(negedge clock_i);
		straps = 3'h0;
		mst.idle_clk();
		mst.rd(7'h48, 1'b1, TSA_PTR_CFG, 1, v);
		chk("strap addr", 16'h0001, {15'h0, mst.ack_ok});
		chk("strap cfg", 16'h0000, v);
		@(negedge clock_i);
		straps = 3'h5;
		mst.idle_clk();
		$display("test defaults done");
	endtask : t_defaults
	task automatic t_queue();
		int n;
		mst.wr(ADDR, TSA_PTR_TRIP, 2, 16'h1900);
		mst.wr(ADDR, TSA_PTR_HYST, 2, 16'h1400);
		for (int c = 0; c < 4; c++) begin
			n = (c == 0) ? 1 : (c == 1) ? 2 : (c == 2) ? 4 : 6;
			cfg({3'h0, c[1:0], 3'h0});
			repeat (n - 1) pulse(9'h040);
			chk("queue short", 16'h0000, {15'h0, alarm_oe});
			pulse(9'h040);
			chk("queue full", 16'h0001, {15'h0, alarm_oe});
			pulse(9'h030);
			chk("between", 16'h0001, {15'h0, alarm_oe});
			repeat (n) pulse(9'h020);
			chk("below hyst", 16'h0000, {15'h0, alarm_oe});
		end
		cfg(8'h08);
		pulse(9'h040);
		pulse(9'h030);
		pulse(9'h040);
		chk("queue reset", 16'h0000, {15'h0, alarm_oe});
		cfg(8'h04);
		chk("pol idle", 16'h0001, {15'h0, alarm_oe});
		pulse(9'h040);
		chk("pol active", 16'h0000, {15'h0, alarm_oe});
		pulse(9'h020);
		chk("pin level", 16'h0000, {14'h0, alarm_o, sda_o});
		$display("test queue done");
	endtask : t_queue
	task automatic t_int();
		cfg(8'h02);
		pulse(9'h040);
		waitc(20);
		chk("int set", 16'h0001, {15'h0, alarm_oe});
		mst.rd(ADDR, 1'b1, TSA_PTR_CFG, 1, v);
		chk("cfg rd", 16'h0200, v);
		waitc(10);
		chk("int clr", 16'h0000, {15'h0, alarm_oe});
		pulse(9'h040);
		chk("no rearm", 16'h0000, {15'h0, alarm_oe});
		pulse(9'h020);
		chk("low int", 16'h0001, {15'h0, alarm_oe});
		cfg(8'h03);
		chk("sd clr", 16'h0000, {15'h0, alarm_oe});
		chk("sd conv", 16'h0000, {15'h0, conv_en});
		mst.wr(ADDR, TSA_PTR_HYST, 2, 16'h1000);
		mst.rd(ADDR, 1'b1, TSA_PTR_HYST, 2, v);
		chk("sd hyst", 16'h1000, v);
		mst.rd(ADDR, 1'b1, TSA_PTR_CFG, 1, v);
		chk("sd cfg", 16'h0300, v);
		$display("test int done");
	endtask : t_int
	initial begin
		clock_i = 1'b0;
		rstn_i = 1'b0;
		res = 9'h000;
		done = 1'b0;
		straps = 3'h5;
		miscompares = 0;
		num_checks = 0;
		cycles = 0;
		repeat (4) @(posedge clock_i);
		@(negedge clock_i);
		rstn_i = 1'b1;
		mst.idle_clk();
		waitc(2);
		chk("conv en", 16'h0001, {15'h0, conv_en});
		chk("alarm idle", 16'h0000, {15'h0, alarm_oe});
		t_temp();
		t_defaults();
		t_queue();
		t_int();
		end_sim();
	end
endmodule : tb
